// file: verilog/tmr4_timer.sv
// Purpose: 8-bit timer with prescaler, four modes and two channels
// Assumes: tick enable and channel inputs synchronous to clk_sys
// Notes: register reads answer one cycle after the read strobe
//
// What this block does
// - Counter value readable, resets to zero
// - Prescaler divides tick by one to 128
// - Run bit advances counter, else holds
// - Clear bit zeroes counter, reads zero
// - Mode 00 counts up and wraps
// - Mode 01 counts down from channel-0 value
// - Mode 10 counts up to channel-0 value
// - Mode 11 counts up then down
// - Each channel has read/write value register
// - Mode bit picks capture or compare
// - Edge field picks capture edges
// - Each channel compares against its own value
// - Match sets, clears or toggles output
// - Code 011 set up, clear zero/down
// - Code 100 clear up, set zero/down
// - Channel 0 codes 101/110 use zero
// - Channel 1 codes 101/110 use channel-0 value
// - Pending flags set by events, cleared by zero
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "tmr4_regs.svh"

module tmr4_timer (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic tick_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [1:0] ch_in,
	output logic [1:0] ch_out,
	output logic irq_req
);

	// Bus request bundle
	tmr4_pkg::tmr4_bus_req_t req;
	// Counter and control state
	logic [7:0] counter_byte;
	logic [7:0] timer4_control_reg;
	tmr4_pkg::tmr4_cctl_t cctl [2];
	logic [7:0] channel_word [2];
	// Pending flags
	logic overflow_pending_flag;
	logic [1:0] ch_pending;
	// Prescaler and direction
	logic [6:0] prescale;
	tmr4_pkg::tmr4_dir_t dir;
	// Previous channel input levels for edge detection
	logic [1:0] ch_in_q;
	// Derived strobes
	logic count_en;
	logic [7:0] next_count;
	tmr4_pkg::tmr4_dir_t next_dir;
	logic overflow;
	logic [1:0] capture_ev;
	logic [1:0] compare_ev;
	logic [1:0] wr_val;
	logic [1:0] wr_cctl;
	logic counter_zero_strobe;
	logic wr_flags;
	tmr4_pkg::tmr4_mode_t mode;
	logic [2:0] div_sel;

	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
	assign mode = tmr4_pkg::tmr4_mode_t'(
		timer4_control_reg[`TMR4_CTL_MODE_MSB:`TMR4_CTL_MODE_LSB]);
	assign div_sel = timer4_control_reg[`TMR4_CTL_DIV_MSB:`TMR4_CTL_DIV_LSB];
	assign wr_flags = req.wr && req.addr == `TMR4_FLAGS_ADDR;
	// Clear strobe: a write with the clear bit high, never stored
	assign counter_zero_strobe = req.wr && req.addr == `TMR4_CONTROL_ADDR
		&& req.wdata[`TMR4_CTL_CLR_BIT];

	// Prescaler enable: the low div_sel bits of the prescale count are all
	// ones on the tick that completes a period
	always_comb begin
		logic [6:0] mask;
		mask = 7'h00;
		// Build a mask of div_sel ones
		for (int i = 0; i < 7; i++) begin
			mask[i] = (3'(i) < div_sel);
		end
		count_en = tick_en && ((prescale & mask) == mask)
			&& timer4_control_reg[`TMR4_CTL_RUN_BIT];
	end

	// Prescale counter runs on the system tick while the timer runs
	always_ff @(posedge clk_sys) begin
		if (srst || counter_zero_strobe) begin
			prescale <= 7'h00;
		end else if (tick_en && timer4_control_reg[`TMR4_CTL_RUN_BIT]) begin
			prescale <= prescale + 7'h01;
		end
	end

	// Next counter value and direction per mode
	always_comb begin
		next_count = counter_byte;
		next_dir = dir;
		overflow = 1'b0;
		case (mode)
			tmr4_pkg::TMR4_FREE: begin
				next_count = counter_byte + 8'h01;
				overflow = counter_byte == `TMR4_MAX;
				next_dir = tmr4_pkg::TMR4_DIR_UP;
			end
			tmr4_pkg::TMR4_DOWN: begin
				// Stops at zero; a single event marks arrival
				next_dir = tmr4_pkg::TMR4_DIR_DOWN;
				if (counter_byte != `TMR4_ZERO) begin
					next_count = counter_byte - 8'h01;
					overflow = counter_byte == 8'h01;
				end
			end
			tmr4_pkg::TMR4_MODULO: begin
				next_dir = tmr4_pkg::TMR4_DIR_UP;
				if (counter_byte == channel_word[0]) begin
					next_count = `TMR4_ZERO;
					overflow = 1'b1;
				end else begin
					next_count = counter_byte + 8'h01;
				end
			end
			tmr4_pkg::TMR4_UPDOWN: begin
				if (dir == tmr4_pkg::TMR4_DIR_UP) begin
					if (counter_byte >= channel_word[0]) begin
						next_dir = tmr4_pkg::TMR4_DIR_DOWN;
						next_count = counter_byte - 8'h01;
						if (counter_byte == `TMR4_ZERO) begin
							next_count = `TMR4_ZERO;
							next_dir = tmr4_pkg::TMR4_DIR_UP;
						end
					end else begin
						next_count = counter_byte + 8'h01;
					end
				end else if (counter_byte == 8'h01
					|| counter_byte == `TMR4_ZERO) begin
					next_count = `TMR4_ZERO;
					next_dir = tmr4_pkg::TMR4_DIR_UP;
					overflow = 1'b1;
				end else begin
					next_count = counter_byte - 8'h01;
				end
			end
			default: begin
				next_count = counter_byte;
			end
		endcase
	end

	// Counter register; a write that switches into the down mode loads channel-0 value
	always_ff @(posedge clk_sys) begin
		if (srst || counter_zero_strobe) begin
			counter_byte <= `TMR4_ZERO;
			dir <= tmr4_pkg::TMR4_DIR_UP;
		end else if (req.wr && req.addr == `TMR4_CONTROL_ADDR
			&& req.wdata[`TMR4_CTL_MODE_MSB:`TMR4_CTL_MODE_LSB] == 2'h1
			&& mode != tmr4_pkg::TMR4_DOWN) begin
			counter_byte <= channel_word[0];
			dir <= tmr4_pkg::TMR4_DIR_DOWN;
		end else if (count_en) begin
			counter_byte <= next_count;
			dir <= next_dir;
		end
	end

	// Timer control register; clear bit is never stored
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			timer4_control_reg <= `TMR4_CONTROL_RST;
		end else if (req.wr && req.addr == `TMR4_CONTROL_ADDR) begin
			timer4_control_reg <= req.wdata
				& ~(8'h01 << `TMR4_CTL_CLR_BIT);
		end
	end

	// Input history for capture edges
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ch_in_q <= 2'h0;
		end else begin
			ch_in_q <= ch_in;
		end
	end

	// Per-channel logic
	generate
		for (genvar c = 0; c < 2; c++) begin : g_ch
			logic rise;
			logic fall;
			logic up_match;
			logic down_match;
			logic at_zero;
			logic alt_ev;
			assign rise = ch_in[c] && !ch_in_q[c];
			assign fall = !ch_in[c] && ch_in_q[c];
			// Capture only in capture operation
			assign capture_ev[c] = !cctl[c].compare && (
				(cctl[c].edge_sel[0] && rise)
				|| (cctl[c].edge_sel[1] && fall));
			// Match judged on the step's target, output moves with it
			assign compare_ev[c] = cctl[c].compare && count_en
				&& next_count == channel_word[c] && next_count != counter_byte;
			assign up_match = compare_ev[c]
				&& !(mode == tmr4_pkg::TMR4_UPDOWN
				&& next_dir == tmr4_pkg::TMR4_DIR_DOWN
				&& dir == tmr4_pkg::TMR4_DIR_DOWN);
			assign down_match = compare_ev[c] && !up_match;
			assign at_zero = cctl[c].compare && count_en
				&& next_count == `TMR4_ZERO && counter_byte != `TMR4_ZERO;
			// Channel 1 second event is the channel-0 value
			assign alt_ev = (c == 0) ? at_zero : (cctl[c].compare && count_en
				&& next_count == channel_word[0]
				&& next_count != counter_byte);
			assign wr_val[c] = req.wr && req.addr == (c == 0 ?
				`TMR4_CH0_VALUE_ADDR : `TMR4_CH1_VALUE_ADDR);
			assign wr_cctl[c] = req.wr && req.addr == (c == 0 ?
				`TMR4_CH0_CONTROL_ADDR : `TMR4_CH1_CONTROL_ADDR);

			// Value register: software write or capture
			always_ff @(posedge clk_sys) begin
				if (srst) begin
					channel_word[c] <= `TMR4_ZERO;
				end else if (capture_ev[c]) begin
					channel_word[c] <= counter_byte;
				end else if (wr_val[c]) begin
					channel_word[c] <= req.wdata;
				end
			end

			// Channel control register, top bit reads zero
			always_ff @(posedge clk_sys) begin
				if (srst) begin
					cctl[c] <= `TMR4_CCTL_RST;
				end else if (wr_cctl[c]) begin
					cctl[c] <= {1'b0, req.wdata[6:0]};
				end
			end

			// Output action on compare events
			always_ff @(posedge clk_sys) begin
				if (srst) begin
					ch_out[c] <= 1'b0;
				end else begin
					case (cctl[c].action)
						tmr4_pkg::TMR4_ACT_SET: begin
							if (compare_ev[c]) ch_out[c] <= 1'b1;
						end
						tmr4_pkg::TMR4_ACT_CLR: begin
							if (compare_ev[c]) ch_out[c] <= 1'b0;
						end
						tmr4_pkg::TMR4_ACT_TGL: begin
							if (compare_ev[c]) ch_out[c] <= !ch_out[c];
						end
						tmr4_pkg::TMR4_ACT_SET_UP: begin
							if (up_match) ch_out[c] <= 1'b1;
							else if (down_match || (at_zero
								&& mode != tmr4_pkg::TMR4_UPDOWN))
								ch_out[c] <= 1'b0;
						end
						tmr4_pkg::TMR4_ACT_CLR_UP: begin
							if (up_match) ch_out[c] <= 1'b0;
							else if (down_match || (at_zero
								&& mode != tmr4_pkg::TMR4_UPDOWN))
								ch_out[c] <= 1'b1;
						end
						tmr4_pkg::TMR4_ACT_SET_ZERO: begin
							if (compare_ev[c]) ch_out[c] <= 1'b1;
							else if (alt_ev) ch_out[c] <= 1'b0;
						end
						tmr4_pkg::TMR4_ACT_CLR_ZERO: begin
							if (compare_ev[c]) ch_out[c] <= 1'b0;
							else if (alt_ev) ch_out[c] <= 1'b1;
						end
						default: begin
							ch_out[c] <= ch_out[c];
						end
					endcase
				end
			end

			// Pending flag: set wins over a zero write
			always_ff @(posedge clk_sys) begin
				if (srst) begin
					ch_pending[c] <= 1'b0;
				end else if (capture_ev[c] || compare_ev[c]) begin
					ch_pending[c] <= 1'b1;
				end else if (wr_flags
					&& !req.wdata[`TMR4_FLG_CH0_BIT + c]) begin
					ch_pending[c] <= 1'b0;
				end
			end
		end
	endgenerate

	// Overflow flag: set wins, only a zero write clears
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			overflow_pending_flag <= 1'b0;
		end else if (count_en && overflow) begin
			overflow_pending_flag <= 1'b1;
		end else if (wr_flags && !req.wdata[`TMR4_FLG_OVF_BIT]) begin
			overflow_pending_flag <= 1'b0;
		end
	end

	// Request to the interrupt controller, registered
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			irq_req <= 1'b0;
		end else begin
			irq_req <= (overflow_pending_flag
				&& timer4_control_reg[`TMR4_CTL_OVFIE_BIT])
				|| (ch_pending[0] && cctl[0].irq_enable)
				|| (ch_pending[1] && cctl[1].irq_enable);
		end
	end

	// Read data one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			reg_rdata <= 8'h00;
		end else if (req.rd) begin
			case (req.addr)
				`TMR4_COUNT_ADDR: reg_rdata <= counter_byte;
				`TMR4_CONTROL_ADDR: reg_rdata <= timer4_control_reg;
				`TMR4_CH0_CONTROL_ADDR: reg_rdata <= cctl[0];
				`TMR4_CH0_VALUE_ADDR: reg_rdata <= channel_word[0];
				`TMR4_CH1_CONTROL_ADDR: reg_rdata <= cctl[1];
				`TMR4_CH1_VALUE_ADDR: reg_rdata <= channel_word[1];
				`TMR4_FLAGS_ADDR: reg_rdata <= {2'h0, ch_pending,
					overflow_pending_flag, 3'h0};
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

endmodule

// file: verilog/tmr4_regs.svh
// Purpose: register offsets, field positions and reset values of the timer
// Assumes: byte-wide register port, offsets are special-function addresses
// Notes: channel 1 value and flag register offsets sit beside the others
`ifndef TMR4_REGS_SVH
`define TMR4_REGS_SVH

// Register offsets
`define TMR4_COUNT_ADDR 8'hea
`define TMR4_CONTROL_ADDR 8'heb
`define TMR4_CH0_CONTROL_ADDR 8'hec
`define TMR4_CH0_VALUE_ADDR 8'hed
`define TMR4_CH1_CONTROL_ADDR 8'hee
`define TMR4_CH1_VALUE_ADDR 8'hef
`define TMR4_FLAGS_ADDR 8'hf0

// Timer control fields
`define TMR4_CTL_DIV_MSB 7
`define TMR4_CTL_DIV_LSB 5
`define TMR4_CTL_RUN_BIT 4
`define TMR4_CTL_OVFIE_BIT 3
`define TMR4_CTL_CLR_BIT 2
`define TMR4_CTL_MODE_MSB 1
`define TMR4_CTL_MODE_LSB 0

// Channel control fields
`define TMR4_CCTL_IE_BIT 6
`define TMR4_CCTL_ACT_MSB 5
`define TMR4_CCTL_ACT_LSB 3
`define TMR4_CCTL_CMP_BIT 2
`define TMR4_CCTL_EDGE_MSB 1
`define TMR4_CCTL_EDGE_LSB 0

// Flag register fields
`define TMR4_FLG_OVF_BIT 3
`define TMR4_FLG_CH0_BIT 4
`define TMR4_FLG_CH1_BIT 5

// Reset values and counter limits
`define TMR4_CONTROL_RST 8'h08
`define TMR4_CCTL_RST 8'h40
`define TMR4_ZERO 8'h00
`define TMR4_MAX 8'hff

`endif

// file: verilog/tmr4_pkg.sv
// Purpose: types used by the timer design, not by its bench
// Assumes: nothing beyond the register header
// Notes: codes follow the control register encodings
package tmr4_pkg;

	// Counter modes
	typedef enum logic [1:0] {
		TMR4_FREE = 2'h0,
		TMR4_DOWN = 2'h1,
		TMR4_MODULO = 2'h2,
		TMR4_UPDOWN = 2'h3
	} tmr4_mode_t;

	// Compare output actions
	typedef enum logic [2:0] {
		TMR4_ACT_SET = 3'h0,
		TMR4_ACT_CLR = 3'h1,
		TMR4_ACT_TGL = 3'h2,
		TMR4_ACT_SET_UP = 3'h3,
		TMR4_ACT_CLR_UP = 3'h4,
		TMR4_ACT_SET_ZERO = 3'h5,
		TMR4_ACT_CLR_ZERO = 3'h6,
		TMR4_ACT_NONE = 3'h7
	} tmr4_action_t;

	// Up/down direction state, Gray ordered
	typedef enum logic {
		TMR4_DIR_UP = 1'b0,
		TMR4_DIR_DOWN = 1'b1
	} tmr4_dir_t;

	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tmr4_bus_req_t;

	// Channel control fields
	typedef struct packed {
		logic unused;
		logic irq_enable;
		tmr4_action_t action;
		logic compare;
		logic [1:0] edge_sel;
	} tmr4_cctl_t;

endpackage

// file: sim/tmr4_timer_asserts.sv
// Purpose: port-level checks of the timer register port and outputs
// Assumes: one clock, synchronous active-high reset
// Notes: sees only the top module ports, attached by bind
`timescale 1ns/1ps
`include "tmr4_regs.svh"

module tmr4_timer_asserts (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic tick_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [1:0] ch_in,
	input wire logic [1:0] ch_out,
	input wire logic irq_req
);
	// Single domain, so one clock for all and one disable for all but the reset check
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	// Outputs settle to zero under reset, reset itself not a disable
	AST_RST_OUTPUTS: assert property (disable iff (1'b0)
		srst |=> reg_rdata == 8'h00 && ch_out == 2'h0 && !irq_req)
		else $error("outputs not zero after reset");
	// Read data stands only in the cycle after a read strobe
	AST_RDATA_IDLE: assert property (
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside a read");
	// Clear bit always reads back low
	AST_CLR_READS_ZERO: assert property (
		reg_rd && reg_addr == `TMR4_CONTROL_ADDR |=> !reg_rdata[2])
		else $error("clear bit read back high");
	// A clear followed at once by a count read gives zero
	AST_CLR_ZEROES: assert property (
		reg_wr && reg_addr == `TMR4_CONTROL_ADDR && reg_wdata[2]
		&& reg_wdata[1:0] != 2'h1
		##1 reg_rd && reg_addr == `TMR4_COUNT_ADDR |=> reg_rdata == 8'h00)
		else $error("count not zero after clear");
	// Unused top bit of a channel control reads zero
	AST_CCTL_BIT7: assert property (
		reg_rd && (reg_addr == `TMR4_CH0_CONTROL_ADDR
		|| reg_addr == `TMR4_CH1_CONTROL_ADDR) |=> !reg_rdata[7])
		else $error("channel control bit 7 read high");
	// Only the three timer flags live in the flag byte
	AST_FLAG_SPARE: assert property (
		reg_rd && reg_addr == `TMR4_FLAGS_ADDR
		|=> (reg_rdata & 8'hc7) == 8'h00)
		else $error("spare flag bits read high");
	// Addresses outside the map answer zero
	AST_UNMAPPED: assert property (
		reg_rd && (reg_addr < 8'hea || reg_addr > 8'hf0)
		|=> reg_rdata == 8'h00)
		else $error("unmapped address read nonzero");
	// No tick and no write means no counter step, so no output change
	AST_OUT_HOLD: assert property (
		!tick_en && !reg_wr |=> ch_out == $past(ch_out))
		else $error("channel output moved without a cause");
	// A request rises only after a tick, a write or an input edge
	AST_IRQ_CAUSE: assert property (
		$rose(irq_req) |-> $past(tick_en) || $past(reg_wr)
		|| $past(tick_en, 2) || $past(reg_wr, 2)
		|| $past(ch_in) != $past(ch_in, 2)
		|| $past(ch_in, 2) != $past(ch_in, 3))
		else $error("request rose without a cause");

	// Main scenarios reached
	COV_IRQ: cover property ($rose(irq_req));
	COV_OUT: cover property ($changed(ch_out));
	COV_CNT_RD: cover property (reg_rd && reg_addr == `TMR4_COUNT_ADDR);
endmodule

bind tmr4_timer tmr4_timer_asserts u_chk (.clk_sys(clk_sys), .srst(srst),
	.tick_en(tick_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.ch_in(ch_in), .ch_out(ch_out), .irq_req(irq_req));

// file: sim/test_tmr4_timer.sv
// Purpose: self-checking bench for the eight-bit timer
// Assumes: register port with read data one cycle after the strobe
// Notes: count expectations come from an integer count model in the bench
`timescale 1ns/1ps
`include "tmr4_regs.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
	$display("BAD t=%0t got %h exp %h", $time, a, e); end end

module test_tmr4_timer;
	logic clk_sys = 0, srst = 1, tick_en = 0, reg_wr = 0, reg_rd = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, v, prev, r;
	logic [1:0] ch_in = 0, ch_out;
	logic irq_req, o1;
	int failures = 0, n_checks = 0, n, chg, k, d;
	int acts[5] = '{0, 1, 2, 7, 2};

	tmr4_timer DUT (.clk_sys(clk_sys), .srst(srst), .tick_en(tick_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .ch_in(ch_in),
		.ch_out(ch_out), .irq_req(irq_req));

	// 100 MHz system clock
	initial forever #5 clk_sys = ~clk_sys;

	// Count model: value after k steps from the mode start point
	function automatic int mcount(int m, int cv, int k);
		int p;
		case (m)
			0: return k % 256;
			1: return (cv > k) ? cv - k : 0; // Down stops at zero
			2: return k % (cv + 1);
			default: begin
				p = k % (2 * cv);
				return (p <= cv) ? p : 2 * cv - p;
			end
		endcase
	endfunction

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys) begin
			reg_wr <= 1;
			reg_addr <= a;
			reg_wdata <= d;
		end
		@(posedge clk_sys) reg_wr <= 0;
	endtask

	// Read strobe, data taken in the following cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(posedge clk_sys) begin
			reg_rd <= 1;
			reg_addr <= a;
		end
		@(posedge clk_sys) reg_rd <= 0;
		#1 q = reg_rdata;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		rd(a, r);
		`CHK(r, e)
	endtask

	// Consecutive high cycles, one tick each; returns once outputs settle
	task automatic ticks(input int t);
		@(posedge clk_sys) tick_en <= 1;
		repeat (t) @(posedge clk_sys);
		tick_en <= 0;
		#1;
	endtask

	// Input change, then one edge for the edge detector
	task automatic pin(input logic [1:0] p);
		@(posedge clk_sys) ch_in <= p;
		@(posedge clk_sys);
	endtask

	task automatic end_of_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Watchdog: the tests need well under 20k cycles
	initial begin
		#500000;
		failures++;
		end_of_test();
	end

	initial begin
		void'($urandom(59));
		repeat (10) @(posedge clk_sys);
		srst <= 0;
		// Reset values of every register, plus an unmapped place
		rchk(8'hea, 8'h00);
		rchk(8'heb, `TMR4_CONTROL_RST);
		rchk(8'hec, `TMR4_CCTL_RST);
		rchk(8'hed, 8'h00);
		rchk(8'hee, `TMR4_CCTL_RST);
		rchk(8'hef, 8'h00);
		rchk(8'hf0, 8'h00);
		rchk(8'h10, 8'h00);
		// Value registers hold random data; count ignores writes
		for (k = 0; k < 4; k++) begin
			v = 8'($urandom);
			wr(8'hed + 8'(2 * (k % 2)), v);
			rchk(8'hed + 8'(2 * (k % 2)), v);
		end
		wr(8'hea, 8'h5a);
		rchk(8'hea, 8'h00);
		// Prescaler: tick spacing between two steps is 2^div
		for (d = 0; d < 8; d++) begin
			wr(8'heb, 8'((d << 5) | 8'h14));
			rd(8'hea, prev);
			n = 0;
			chg = 0;
			while (chg < 2 && n < 300) begin
				ticks(1);
				n++;
				rd(8'hea, v);
				if (v !== prev) begin
					if (chg == 1) `CHK(n, 1 << d)
					chg++;
					n = 0;
					prev = v;
				end
			end
			`CHK(chg, 2)
		end
		// Suspended counter holds; clear bit reads low
		wr(8'heb, 8'h1c);
		rchk(8'heb, 8'h18);
		ticks(3);
		wr(8'heb, 8'h08);
		ticks(5);
		rchk(8'hea, 8'(mcount(0, 0, 3)));
		// Clear written with a count read straight behind it
		@(posedge clk_sys) begin
			reg_wr <= 1;
			reg_addr <= 8'heb;
			reg_wdata <= 8'h0c;
		end
		@(posedge clk_sys) begin
			reg_wr <= 0;
			reg_rd <= 1;
			reg_addr <= 8'hea;
		end
		@(posedge clk_sys) reg_rd <= 0;
		#1 `CHK(reg_rdata, 8'h00)
		// Free run wraps, flags overflow, write one leaves flag
		wr(8'hf0, 8'h00);
		wr(8'heb, 8'h1c);
		ticks(256);
		rchk(8'hea, 8'(mcount(0, 0, 256)));
		wr(8'hf0, 8'hff);
		rchk(8'hf0, 8'h08);
		`CHK(irq_req, 1'b1)
		wr(8'hf0, 8'h00);
		rchk(8'hf0, 8'h00);
		wr(8'heb, 8'h14);
		ticks(256);
		rchk(8'hf0, 8'h08);
		`CHK(irq_req, 1'b0)
		wr(8'hf0, 8'h00);
		// Modulo, up/down and down modes against the model
		wr(8'hed, 8'h05);
		wr(8'heb, 8'h16);
		ticks(8);
		rchk(8'hea, 8'(mcount(2, 5, 8)));
		wr(8'hed, 8'h03);
		wr(8'heb, 8'h17);
		ticks(5);
		rchk(8'hea, 8'(mcount(3, 3, 5)));
		wr(8'hed, 8'h04);
		wr(8'heb, 8'h11);
		ticks(2);
		rchk(8'hea, 8'(mcount(1, 4, 2)));
		ticks(5);
		rchk(8'hea, 8'(mcount(1, 4, 7)));
		// Channel 1 compare at its own value, action codes 000, 001, 010 and 111
		wr(8'hef, 8'h07);
		o1 = 1'b0;
		foreach (acts[i]) begin
			wr(8'hee, 8'(8'h04 | (acts[i] << 3)));
			wr(8'heb, 8'h14);
			ticks(6);
			`CHK(ch_out[1], o1)
			ticks(1);
			if (acts[i] == 0) o1 = 1'b1;
			else if (acts[i] == 1) o1 = 1'b0;
			else if (acts[i] == 2) o1 = ~o1;
			`CHK(ch_out[1], o1)
		end
		// Up/down to 6: channel 0 code 011 sets at the top, channel 1
		// code 100 clears going up through 3 and sets coming down
		wr(8'hed, 8'h06);
		wr(8'hef, 8'h03);
		wr(8'hec, 8'h1c);
		wr(8'hee, 8'h24);
		wr(8'heb, 8'h17);
		ticks(6);
		`CHK(ch_out, 2'b01)
		ticks(3);
		`CHK(ch_out, 2'b11)
		ticks(6);
		`CHK(ch_out, 2'b01)
		// Modulo at 6: channel 0 code 101 sets at 6, clears at zero;
		// channel 1 code 110 clears at 3, sets at the channel-0 value
		wr(8'hec, 8'h2c);
		wr(8'hee, 8'h34);
		wr(8'heb, 8'h16);
		ticks(6);
		`CHK(ch_out, 2'b11)
		ticks(1);
		`CHK(ch_out, 2'b10)
		ticks(3);
		`CHK(ch_out, 2'b00)
		ticks(3);
		`CHK(ch_out, 2'b11)
		// Capture on each edge code with the counter parked at 9
		wr(8'heb, 8'h14);
		ticks(9);
		wr(8'heb, 8'h00);
		for (k = 0; k < 4; k++) begin
			wr(8'hf0, 8'h00);
			wr(8'hed, 8'h00);
			wr(8'hec, 8'(k | ((k < 3) ? 8'h40 : 8'h00)));
			pin(2'b01);
			rchk(8'hed, (k % 2) ? 8'h09 : 8'h00);
			wr(8'hed, 8'h00);
			pin(2'b00);
			rchk(8'hed, (k / 2) ? 8'h09 : 8'h00);
			rchk(8'hf0, (k != 0) ? 8'h10 : 8'h00);
			`CHK(irq_req, 1'(k == 1 || k == 2))
		end
		// Mid-run reset puts registers back to their reset values
		@(posedge clk_sys) srst <= 1;
		repeat (2) @(posedge clk_sys);
		srst <= 0;
		rchk(8'hed, 8'h00);
		rchk(8'heb, `TMR4_CONTROL_RST);
		end_of_test();
	end
endmodule
